// >>> core/dflr_pkg.sv
/*
 Package for the drive fault latch and reset block: fault word layout,
 fault codes, acknowledge timing, controller register map and history depth.
 Assumes a single 200 MHz clock shared by both ends.
*/
//
// Overview of operation
// RULE1 - Show active fault as number and text code
// RULE2 - Faults one to six cannot be acknowledged
// RULE3 - Reset line high 100 ms acknowledges faults
// RULE4 - Fieldbus reset bit 100 ms acknowledges faults
// RULE5 - Controller drops on and run before acknowledge
// RULE6 - Controller reasserts on and run after acknowledge
// RULE7 - Any latched fault drops main contactor output
// RULE8 - Flash or thyristor short sets bit 1
// RULE9 - Firmware error sets bit 2
// RULE10 - Bad parameter checksum sets bit 3, defaults
// RULE11 - Incompatible parameters set bit 4, record number
// RULE12 - Bad type data checksum sets bit 5
// RULE13 - Overtemperature sets bit 6, clear after cooling
// RULE14 - Mains sync lost in operation sets bit 10
// RULE15 - Keep history of last sixteen faults
// RULE16 - Fault bits stay latched until acknowledged
package dflr_pkg;

  localparam int          FW_WIDTH         = 16;
  localparam int          FB_AUX           = 0;
  localparam int          FB_HARDWARE      = 1;
  localparam int          FB_SOFTWARE      = 2;
  localparam int          FB_PAR_CHECKSUM  = 3;
  localparam int          FB_COMPAT        = 4;
  localparam int          FB_TYPECODE      = 5;
  localparam int          FB_OVERTEMP      = 6;
  localparam int          FB_MAINS_SYNC    = 10;
  localparam logic [15:0] FW_RESET         = 16'h0000;
  // Bits 0..5 belong to the boot and hardware class that refuses acknowledge.
  localparam logic [15:0] FW_LOCKED_MASK   = 16'h003F;

  localparam logic [3:0]  FCODE_NONE       = 4'h0;
  localparam logic [3:0]  CONVERTER_OVERTEMP_CODE = 4'h7;
  localparam logic [3:0]  FCODE_MAINS_SYNC = 4'hB;

  localparam int          CLK_MHZ          = 200;
  localparam int          ACK_HOLD_MS      = 100;
  localparam int          ACK_HOLD_CYCLES  = ACK_HOLD_MS * 1000 * CLK_MHZ;

  localparam int          HIST_DEPTH       = 16;
  localparam logic [15:0] DIAG_RESET       = 16'h0000;

  // Controller register byte offsets on the Avalon-MM port.
  localparam logic [3:0]  REG_CTRL         = 4'h0;
  localparam logic [3:0]  REG_STATUS       = 4'h4;
  localparam logic [3:0]  REG_IRQ_STATUS   = 4'h8;
  localparam logic [3:0]  REG_IRQ_MASK     = 4'hC;
  localparam logic [31:0] RD_UNMAPPED      = 32'h0000_0000;
  localparam int          CTRL_ON          = 0;
  localparam int          CTRL_RUN         = 1;
  localparam int          CTRL_ACK         = 2;
  localparam int          IRQ_FAULT        = 0;
  localparam int          IRQ_ACK_DONE     = 1;

endpackage

// >>> core/dflr_if.sv
/*
 Link between the drive fault supervisor and the external controller.
 Assumes both ends share mclk; all signals are plain levels.
*/
`timescale 1ns/1ps
`default_nettype none
interface dflr_if;
  logic        power_on_cmd;
  logic        run_cmd;
  logic        fault_ack_input_line;
  logic        fieldbus_sel;
  logic        fieldbus_reset_bit;
  logic        contactor_on;
  logic        fault_active;
  logic [15:0] fault_word_primary;

  modport device (
    input  power_on_cmd, run_cmd, fault_ack_input_line, fieldbus_sel,
    input  fieldbus_reset_bit,
    output contactor_on, fault_active, fault_word_primary
  );
  modport ctrl (
    output power_on_cmd, run_cmd, fault_ack_input_line, fieldbus_sel,
    output fieldbus_reset_bit,
    input  contactor_on, fault_active, fault_word_primary
  );
endinterface
`default_nettype wire

// >>> core/dflr_hold_timer.sv
/*
 Hold timer: pulses once when its input has stayed high for HOLD cycles.
 Assumes a synchronous input in the mclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dflr_hold_timer
  import dflr_pkg::*;
#(
  parameter int HOLD = ACK_HOLD_CYCLES
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic level,
  output logic      held
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        held;
  } dflr_ht_t;
  dflr_ht_t s;
  dflr_ht_t next_s;

  always_comb begin
    next_s = s;
    next_s.held = 1'b0;
    if (!level) begin
      next_s.cnt = 32'h0000_0000;
    end else if (s.cnt < 32'(HOLD - 1)) begin
      next_s.cnt = s.cnt + 32'h0000_0001;
    end else if (s.cnt == 32'(HOLD - 1)) begin
      // Fires once per hold; the counter parks so a long press acts once.
      next_s.cnt = s.cnt + 32'h0000_0001;
      next_s.held = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign held = s.held;
endmodule
`default_nettype wire

// >>> core/dflr_device.sv
/*
 Drive fault supervisor: latches fault causes into the primary fault word,
 shows the lowest active fault code, drops the main contactor and accepts
 acknowledgement from the panel key, the reset line or the fieldbus bit.
 Assumes fault cause inputs are synchronous single-cycle-or-longer levels;
 link inputs arrive as pins; the reset line, fieldbus select and reset bit are synchronised here, power_on_cmd is not.
*/
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dflr_device
  import dflr_pkg::*;
#(
  parameter int ACK_HOLD = ACK_HOLD_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  dflr_if.device           lnk,
  input  wire logic        panel_reset_key,
  input  wire logic        cause_aux,
  input  wire logic        cause_flash,
  input  wire logic        cause_thyristor_short,
  input  wire logic        cause_firmware,
  input  wire logic        cause_par_checksum,
  input  wire logic        cause_compat,
  input  wire logic [15:0] compat_param_no,
  input  wire logic        cause_typecode,
  input  wire logic        cause_overtemp,
  input  wire logic        cause_mains_sync,
  input  wire logic        drive_operating,
  input  wire logic [3:0]  hist_index,
  output logic [3:0]       fault_code,
  output logic             fault_text_valid,
  output logic             param_defaults_all,
  output logic             param_defaults_some,
  output logic [15:0]      diagnosis,
  output logic [15:0]      hist_word,
  output logic [3:0]       hist_count
);
  typedef struct packed {
    logic [1:0]  sy_ack;
    logic [1:0]  sy_ack2;
    logic [1:0]  sy_sel;
    logic [1:0]  sy_fb;
    logic [1:0]  sy_key;
    logic [1:0]  sy_key2;
    logic [15:0] fw;
    logic [15:0] diag;
    logic [3:0]  code;
    logic        contactor;
    logic        defaults_all;
    logic        defaults_some;
    logic [3:0]  wr_ptr;
    logic [3:0]  count;
    logic [15:0] hist_out;
  } dflr_dev_t;

  dflr_dev_t   s;
  dflr_dev_t   next_s;
  logic [15:0] hist_mem [HIST_DEPTH];
  logic [15:0] set_bits;
  logic        line_held;
  logic        fb_held;
  logic        ack;

  function automatic logic [3:0] lowest_code(input logic [15:0] w);
    logic [3:0] c;
    c = FCODE_NONE;
    for (int i = FW_WIDTH - 1; i >= 0; i--) begin
      if (w[i]) begin
        c = 4'(i + 1);
      end
    end
    return c;
  endfunction

  dflr_hold_timer #(.HOLD(ACK_HOLD)) u_line_timer (
    .mclk  (mclk),
    .nrst  (nrst),
    .level (s.sy_ack2[1]),
    .held  (line_held)
  );

  dflr_hold_timer #(.HOLD(ACK_HOLD)) u_fb_timer (
    .mclk  (mclk),
    .nrst  (nrst),
    .level (s.sy_fb[1] & s.sy_sel[1]),
    .held  (fb_held)
  );

  always_comb begin
    set_bits = 16'h0000;
    set_bits[FB_AUX]          = cause_aux;
    set_bits[FB_HARDWARE]     = cause_flash | cause_thyristor_short;  // [RULE8]
    set_bits[FB_SOFTWARE]     = cause_firmware;                       // [RULE9]
    set_bits[FB_PAR_CHECKSUM] = cause_par_checksum;                   // [RULE10]
    set_bits[FB_COMPAT]       = cause_compat;                         // [RULE11]
    set_bits[FB_TYPECODE]     = cause_typecode;                       // [RULE12]
    set_bits[FB_OVERTEMP]     = cause_overtemp;                       // [RULE13]
    set_bits[FB_MAINS_SYNC]   = cause_mains_sync & drive_operating;   // [RULE14]
    // The panel key is a pin too, so it also passes four flops and is edge-taken.
    ack = line_held | fb_held | (s.sy_key2[1] & ~s.sy_key2[0]);       // [RULE3] [RULE4]
  end

  always_comb begin
    next_s = s;
    next_s.sy_ack  = {s.sy_ack[0], lnk.fault_ack_input_line};
    next_s.sy_ack2 = {s.sy_ack2[0], s.sy_ack[1]};
    next_s.sy_sel  = {s.sy_sel[0], lnk.fieldbus_sel};
    next_s.sy_fb   = {s.sy_fb[0], lnk.fieldbus_reset_bit};
    next_s.sy_key  = {s.sy_key[0], panel_reset_key};
    next_s.sy_key2 = {s.sy_key2[0], s.sy_key[1]};
    // Acknowledge clears only unlocked bits whose cause is gone; a cause that is
    // still present in the same cycle keeps its bit, so set wins over clear.
    if (ack) begin
      next_s.fw = s.fw & (FW_LOCKED_MASK | set_bits);                 // [RULE2] [RULE13] [RULE16]
    end
    next_s.fw = next_s.fw | set_bits;                                 // [RULE16]
    next_s.defaults_all  = s.defaults_all | cause_par_checksum;       // [RULE10]
    next_s.defaults_some = s.defaults_some | cause_compat;            // [RULE11]
    if (cause_compat) begin
      next_s.diag = compat_param_no;                                  // [RULE11]
    end
    next_s.code = lowest_code(next_s.fw);                             // [RULE1]
    next_s.contactor = (next_s.fw == 16'h0000) & lnk.power_on_cmd;    // [RULE7]
    if ((set_bits & ~s.fw) != 16'h0000) begin
      next_s.wr_ptr = s.wr_ptr + 4'h1;                                // [RULE15]
      if (s.count != 4'hF) begin
        next_s.count = s.count + 4'h1;
      end
    end
    next_s.hist_out = hist_mem[hist_index];
  end

  // History is a ring of newly raised fault word snapshots.
  always_ff @(posedge mclk) begin
    if ((set_bits & ~s.fw) != 16'h0000) begin
      hist_mem[s.wr_ptr] <= s.fw | set_bits;                          // [RULE15]
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.fw <= FW_RESET;
      s.diag <= DIAG_RESET;
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    lnk.contactor_on       = s.contactor;
    lnk.fault_active       = (s.code != FCODE_NONE);
    lnk.fault_word_primary = s.fw;
  end

  assign fault_code          = s.code;
  assign fault_text_valid    = (s.code != FCODE_NONE);
  assign param_defaults_all  = s.defaults_all;
  assign param_defaults_some = s.defaults_some;
  assign diagnosis           = s.diag;
  assign hist_word           = s.hist_out;
  assign hist_count          = s.count;
endmodule
`default_nettype wire

// >>> core/dflr_ctrl.sv
/*
 External controller end: software drives on, run and acknowledge through
 Avalon-MM registers; acknowledge first drops on and run, then holds the
 reset line (or fieldbus bit) for the hold time, then restores on and run.
 Assumes the device answers on the shared mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module dflr_ctrl
  import dflr_pkg::*;
#(
  parameter int ACK_HOLD = ACK_HOLD_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  dflr_if.ctrl             lnk,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq
);
  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_DROP = 2'b01,
    C_HOLD = 2'b10,
    C_BACK = 2'b11
  } dflr_cst_t;

  typedef struct packed {
    dflr_cst_t   st;
    logic        on;
    logic        run;
    logic        use_fb;
    logic [31:0] cnt;
    logic        pin_ack;
    logic        pin_fb;
    logic        pin_on;
    logic        pin_run;
    logic [1:0]  sy_fault;
    logic [1:0]  irq_st;
    logic [1:0]  irq_mask;
    logic        irq;
    logic [31:0] rdata;
    logic        ack_done;
    logic        wreq;
  } dflr_ctl_t;

  dflr_ctl_t s;
  dflr_ctl_t next_s;
  logic      fault_rise;

  always_comb begin
    next_s = s;
    next_s.sy_fault = {s.sy_fault[0], lnk.fault_active};
    fault_rise = 1'b0;
    next_s.ack_done = 1'b0;
    // One wait state on every access: read data are registered in the first cycle, so they
    // stand at the edge where the master sees waitrequest low, and writes land at that edge.
    next_s.wreq = !((avs_read || avs_write) && s.wreq);
    unique case (s.st)
      C_IDLE: begin
      end
      C_DROP: begin
        next_s.st = C_HOLD;
        next_s.cnt = 32'h0000_0000;
      end
      C_HOLD: begin
        // Four cycles of margin over the device's count absorb its synchroniser.
        if (s.cnt == 32'(ACK_HOLD + 3)) begin
          next_s.st = C_BACK;
        end else begin
          next_s.cnt = s.cnt + 32'h0000_0001;                         // [RULE3] [RULE4]
        end
      end
      C_BACK: begin
        next_s.st = C_IDLE;
        next_s.ack_done = 1'b1;
      end
    endcase
    next_s.pin_on  = s.on & (s.st == C_IDLE);                         // [RULE5] [RULE6]
    next_s.pin_run = s.run & (s.st == C_IDLE);                        // [RULE5] [RULE6]
    next_s.pin_ack = (s.st == C_HOLD) & ~s.use_fb;                    // [RULE3]
    next_s.pin_fb  = (s.st == C_HOLD) & s.use_fb;                     // [RULE4]
    fault_rise = s.sy_fault[1] & ~s.sy_fault[0] ? 1'b0 : s.sy_fault[0] & ~s.sy_fault[1];
    if (avs_write && !s.wreq) begin
      unique case (avs_address)
        REG_CTRL: begin
          next_s.on = avs_writedata[CTRL_ON];
          next_s.run = avs_writedata[CTRL_RUN];
          next_s.use_fb = avs_writedata[3];
          if (avs_writedata[CTRL_ACK] && s.st == C_IDLE) begin
            next_s.st = C_DROP;                                       // [RULE5]
          end
        end
        REG_IRQ_MASK: next_s.irq_mask = avs_writedata[1:0];
        default: begin
        end
      endcase
    end
    if (avs_read && s.wreq) begin
      unique case (avs_address)
        REG_CTRL:       next_s.rdata = {28'h0000000, s.use_fb, 1'b0, s.run, s.on};
        REG_STATUS:     next_s.rdata = {13'h0000, s.st, s.sy_fault[1], lnk.fault_word_primary};
        REG_IRQ_STATUS: next_s.rdata = {30'h00000000, s.irq_st};
        REG_IRQ_MASK:   next_s.rdata = {30'h00000000, s.irq_mask};
        default:        next_s.rdata = RD_UNMAPPED;
      endcase
      if (avs_address == REG_IRQ_STATUS) begin
        next_s.irq_st = 2'b00;
      end
    end
    // Events arriving during the clearing read still land.
    next_s.irq_st[IRQ_FAULT]    = next_s.irq_st[IRQ_FAULT] | fault_rise;
    next_s.irq_st[IRQ_ACK_DONE] = next_s.irq_st[IRQ_ACK_DONE] | next_s.ack_done;
    next_s.irq = (next_s.irq_st & next_s.irq_mask) != 2'b00;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.st <= C_IDLE;
      s.wreq <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    lnk.power_on_cmd         = s.pin_on;
    lnk.run_cmd              = s.pin_run;
    lnk.fault_ack_input_line = s.pin_ack;
    lnk.fieldbus_sel         = s.use_fb;
    lnk.fieldbus_reset_bit   = s.pin_fb;
  end

  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = s.wreq;
  assign irq             = s.irq;
endmodule
`default_nettype wire

// >>> sim/dflr_monitor.sv
/*
 Link checker: watches the signals between fault supervisor and controller.
 Assumes one mclk domain and instantiation beside the link interface.
*/
`timescale 1ns/1ps
`default_nettype none
module dflr_monitor
  import dflr_pkg::*;
#(
  parameter int ACK_HOLD = ACK_HOLD_CYCLES
) (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        power_on_cmd,
  input wire logic        run_cmd,
  input wire logic        fault_ack_input_line,
  input wire logic        fieldbus_sel,
  input wire logic        fieldbus_reset_bit,
  input wire logic        contactor_on,
  input wire logic        fault_active,
  input wire logic [15:0] fault_word_primary
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // A latched bit may only fall a few cycles after a request held long enough.
  int line_cnt;
  int bus_cnt;
  int since_ack;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      line_cnt  <= 0;
      bus_cnt   <= 0;
      since_ack <= 255;
    end else begin
      line_cnt  <= fault_ack_input_line ? line_cnt + 1 : 0;
      bus_cnt   <= (fieldbus_sel && fieldbus_reset_bit) ? bus_cnt + 1 : 0;
      since_ack <= (line_cnt >= ACK_HOLD || bus_cnt >= ACK_HOLD) ? 0 :
                   (since_ack < 255 ? since_ack + 1 : 255);
    end
  end
  fault_shown_a: assert property (
    (fault_word_primary != 16'h0000) [*2] |-> fault_active)
    else $error("Fault word set but no fault shown.");
  fault_gone_a: assert property (
    (fault_word_primary == 16'h0000) [*2] |-> !fault_active)
    else $error("Fault shown with empty fault word.");
  locked_bits_a: assert property (
    !(|($past(fault_word_primary) & ~fault_word_primary & FW_LOCKED_MASK)))
    else $error("Locked fault bit was cleared.");
  latch_hold_a: assert property (
    (|($past(fault_word_primary) & ~fault_word_primary)) |-> since_ack <= 4)
    else $error("Fault bit fell without a held acknowledge.");
  line_hold_a: assert property (
    $fell(fault_ack_input_line) |-> line_cnt >= ACK_HOLD + 2)
    else $error("Reset line released too early.");
  bus_hold_a: assert property (
    $fell(fieldbus_reset_bit) |-> bus_cnt >= ACK_HOLD + 2)
    else $error("Fieldbus reset bit released too early.");
  cmds_drop_a: assert property (
    $rose(fault_ack_input_line) || $rose(fieldbus_reset_bit) |-> !power_on_cmd && !run_cmd)
    else $error("Acknowledge raised while on or run set.");
  contactor_off_a: assert property (
    (fault_word_primary != 16'h0000) [*3] |-> !contactor_on)
    else $error("Contactor energized with a latched fault.");
  contactor_cmd_a: assert property (
    contactor_on |-> $past(power_on_cmd))
    else $error("Contactor energized without power-on command.");
endmodule
`default_nettype wire

// >>> sim/drive_fault_latch_reset_tb_top.sv
/*
 Self-checking bench: supervisor and controller joined by the link, run
 through the Avalon-MM port and the supervisor's fault cause inputs.
 Assumes a shortened acknowledge hold of a few tens of cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module drive_fault_latch_reset_tb_top
  import dflr_pkg::*;
;
  localparam int HOLD = 20;
  localparam int BPOS [7] = '{0, 1, 1, 2, 3, 4, 5};
  typedef struct packed {logic [3:0] src; logic [31:0] exp; logic [31:0] msk;} dflr_note_t;
  dflr_note_t  notes[$];
  int          mismatches = 0;
  int          num_checks = 0;
  logic        mclk = 1'b0, nrst = 1'b0, samp = 1'b0, op = 1'b0, key = 1'b0;
  logic [8:0]  cz = 9'h000;
  logic [15:0] cpn = 16'h0000;
  logic [3:0]  hidx = 4'h0, avs_address = 4'h0;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic        avs_waitrequest, irq, fault_text_valid, param_defaults_all, param_defaults_some;
  logic [3:0]  fault_code, hist_count;
  logic [15:0] diagnosis, hist_word;

  dflr_if lnk ();
  dflr_device #(.ACK_HOLD(HOLD)) dflr_device_i (.mclk, .nrst, .lnk(lnk.device),
    .panel_reset_key(key), .cause_aux(cz[0]), .cause_flash(cz[1]),
    .cause_thyristor_short(cz[2]), .cause_firmware(cz[3]), .cause_par_checksum(cz[4]),
    .cause_compat(cz[5]), .compat_param_no(cpn), .cause_typecode(cz[6]),
    .cause_overtemp(cz[7]), .cause_mains_sync(cz[8]), .drive_operating(op),
    .hist_index(hidx), .fault_code, .fault_text_valid, .param_defaults_all,
    .param_defaults_some, .diagnosis, .hist_word, .hist_count);
  dflr_ctrl #(.ACK_HOLD(HOLD)) dflr_ctrl_i (.mclk, .nrst, .lnk(lnk.ctrl), .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq);
  dflr_monitor #(.ACK_HOLD(HOLD)) dflr_monitor_i (.mclk, .nrst,
    .power_on_cmd(lnk.power_on_cmd), .run_cmd(lnk.run_cmd),
    .fault_ack_input_line(lnk.fault_ack_input_line), .fieldbus_sel(lnk.fieldbus_sel),
    .fieldbus_reset_bit(lnk.fieldbus_reset_bit), .contactor_on(lnk.contactor_on),
    .fault_active(lnk.fault_active), .fault_word_primary(lnk.fault_word_primary));

  always #2.5 mclk = ~mclk;

  task automatic complete_run();
    if (mismatches == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp();
    dflr_note_t  n;
    logic [31:0] got;
    n = notes.pop_front();
    case (n.src)
      4'h0: got = avs_readdata;
      4'h1: got = {28'h0, fault_code};
      4'h2: got = {16'h0, diagnosis};
      4'h3: got = {28'h0, hist_count};
      4'h4: got = {29'h0, lnk.contactor_on, lnk.power_on_cmd, lnk.run_cmd};
      4'h6: got = {16'h0, hist_word};
      default: got = {28'h0, fault_text_valid, irq, param_defaults_all, param_defaults_some};
    endcase
    num_checks++;
    if ((got & n.msk) !== (n.exp & n.msk)) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got & n.msk, n.exp & n.msk);
    end
  endtask

  // Read data are taken at the very edge where waitrequest is seen low.
  always @(posedge mclk) begin
    if (avs_read && avs_waitrequest === 1'b0) cmp();
    if (samp) cmp();
  end

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{4'h0, e, m});
    bus(1'b0, a, 32'h0);
  endtask

  task automatic chk(input logic [3:0] s, input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{s, e, m});
    samp <= 1'b1;
    @(posedge mclk);
    samp <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic ack(input logic fb);
    int n;
    n = 0;
    bus(1'b1, REG_CTRL, {28'h0, fb, 3'b111});
    // Poll at least once: read data from an earlier acknowledge still stand.
    do begin
      rd(REG_IRQ_STATUS, 32'h0, 32'h0);
      n++;
    end while (avs_readdata[IRQ_ACK_DONE] !== 1'b1 && n < 60);
    if (avs_readdata[IRQ_ACK_DONE] !== 1'b1) mismatches++;
  endtask

  task automatic hit(input int i);
    @(posedge mclk);
    cz[i] <= 1'b1;
    @(posedge mclk);
    cz[i] <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  initial begin
    logic [15:0] pn;
    void'($urandom(32'h1FCBEE7D));
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    bus(1'b1, REG_IRQ_MASK, 32'h3);
    rd(REG_IRQ_MASK, 32'h3, 32'h3);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF);
    rd(4'h2, RD_UNMAPPED, 32'hFFFF_FFFF);
    bus(1'b1, REG_CTRL, 32'h3);
    rd(REG_STATUS, 32'h0, 32'h1FFFF);
    chk(4'h4, 32'h7, 32'h7);
    cz[7] <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(REG_STATUS, 32'h1_0040, 32'h1FFFF);
    chk(4'h1, {28'h0, CONVERTER_OVERTEMP_CODE}, 32'hF);
    chk(4'h5, 32'hC, 32'hC);
    chk(4'h4, 32'h3, 32'h7);
    rd(REG_IRQ_STATUS, 32'h1, 32'h1);
    rd(REG_IRQ_STATUS, 32'h0, 32'h1);
    chk(4'h5, 32'h8, 32'h4);
    ack(1'b0);
    rd(REG_STATUS, 32'h0040, 32'hFFFF);
    cz[7] <= 1'b0;
    ack(1'b0);
    rd(REG_STATUS, 32'h0, 32'hFFFF);
    chk(4'h4, 32'h7, 32'h7);
    hit(8);
    rd(REG_STATUS, 32'h0, 32'hFFFF);
    op <= 1'b1;
    hit(8);
    repeat (8) @(posedge mclk);
    rd(REG_STATUS, 32'h0400, 32'hFFFF);
    chk(4'h1, {28'h0, FCODE_MAINS_SYNC}, 32'hF);
    ack(1'b1);
    rd(REG_STATUS, 32'h0, 32'hFFFF);
    for (int i = 0; i < 7; i++) begin
      nrst <= 1'b0;
      @(posedge mclk);
      nrst <= 1'b1;
      pn = 16'($urandom);
      cpn <= pn;
      hidx <= 4'h0;
      bus(1'b1, REG_CTRL, 32'h3);
      hit(i);
      rd(REG_STATUS, 32'h1_0000 | (32'h1 << BPOS[i]), 32'h1FFFF);
      chk(4'h1, 32'(BPOS[i] + 1), 32'hF);
      chk(4'h4, 32'h3, 32'h7);
      chk(4'h5, {30'h0, i == 4, i == 5}, 32'h3);
      chk(4'h3, 32'h1, 32'hF);
      chk(4'h6, 32'h1 << BPOS[i], 32'hFFFF);
      if (i == 5) chk(4'h2, {16'h0, pn}, 32'hFFFF);
      ack(1'b0);
      rd(REG_STATUS, 32'h1 << BPOS[i], 32'hFFFF);
    end
    complete_run();
  end

  initial begin
    #100us;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
